// File: page_vector_pkg.sv
// constants and carrier types for program paging and vector relocation
package page_vector_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PAGE_W = 4;
    localparam int MMR_ADDR_W = 8;
    localparam logic [MMR_ADDR_W-1:0] MMR_LAST = 8'h1F;
    localparam logic [MMR_ADDR_W-1:0] MODE_STATUS_OFFSET = 8'h1D;
    localparam logic [MMR_ADDR_W-1:0] PAGE_EXT_OFFSET = 8'h1E;
    localparam int VECTOR_POINTER_LSB = 7;
    localparam int VECTOR_POINTER_W = 9;
    localparam int OVERLAY_BIT = 5;
    localparam logic [DATA_W-1:0] MODE_STATUS_RESET = 16'hFF80;
    localparam logic [PAGE_W-1:0] PAGE_EXT_RESET = 4'h0;
    localparam logic [ADDR_W-1:0] COMMON_LAST = 16'h5FFF;
    localparam logic [1:0] VECTOR_STRIDE_SHIFT = 2'h2;
    localparam logic [ADDR_W-1:0] RESET_VECTOR = 16'hFF80;
    localparam logic [PAGE_W-1:0] SHADOW_WORDS_LOG2 = 4'h5;
    typedef enum logic [3:0] {
        OP_NONE, OP_FAR_BRANCH, OP_FAR_BRANCH_ACC, OP_FAR_CALL, OP_FAR_CALL_ACC,
        OP_FAR_RETURN, OP_FAR_RETURN_IE, OP_PROG_READ_ACC, OP_PROG_WRITE_ACC
    } far_op_type;
    typedef struct packed {
        far_op_type op;
        logic [PAGE_W-1:0] page;
        logic [ADDR_W-1:0] addr;
    } far_request_type;
    typedef struct packed {
        logic [PAGE_W-1:0] page;
        logic [ADDR_W-1:0] addr;
        logic on_chip;
    } program_address_type;
endpackage

// File: mmr_shadow.sv
// small register store for the reserved core mmr slots
`timescale 1ns/100ps
`default_nettype none
module mmr_shadow
    import page_vector_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [4:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic [4:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [0:(1<<SHADOW_WORDS_LOG2)-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

// File: program_page_vector_relocation.sv
// program page extension, overlay routing and vector relocation logic
// Behaviour
// - four upper lines extend space to 1M
// - page selects one of 64K-word pages
// - eight far ops and writes to the page register drive pages
// - overlay gives shared 24K common block
// - page from extension register, reset zero
// - low 24K on-chip if overlay, else external
// - trap loads pc with vector address
// - vectors spaced four words apart
// - after reset vectors at FF80h
// - vector pointer relocates later vectors
// - hardware reset sets pointer all ones
// - core registers decode in 0h..1Fh
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module program_page_vector_relocation
    import page_vector_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [MMR_ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    input wire page_vector_pkg::far_request_type FAR_REQ,
    input wire logic FAR_VALID,
    input wire logic TRAP_TAKE,
    input wire logic [4:0] TRAP_NUMBER,
    input wire logic [ADDR_W-1:0] PC_NEXT,
    output logic [ADDR_W-1:0] PROGRAM_COUNTER,
    output logic [PAGE_W-1:0] UPPER_PROGRAM_ADDRESS_LINES,
    output logic [ADDR_W-1:0] PROGRAM_ADDRESS,
    output logic PROGRAM_ON_CHIP,
    output logic PROGRAM_WRITE,
    output logic OVERLAY_SELECT
);
    import page_vector_pkg::*;

    typedef enum logic [1:0] {
        READ_NONE,
        READ_MODE_STATUS,
        READ_PAGE_EXT,
        READ_SHADOW
    } read_source_type;

    logic [DATA_W-1:0] mode_status_q;
    logic [PAGE_W-1:0] page_ext_q;
    logic [ADDR_W-1:0] pc_q;
    logic [PAGE_W-1:0] page_out_q;
    logic [ADDR_W-1:0] addr_out_q;
    logic on_chip_q;
    logic write_q;
    logic acc_valid_q;
    logic acc_write_q;
    logic [PAGE_W-1:0] acc_page_q;
    logic [ADDR_W-1:0] acc_addr_q;
    read_source_type read_source_q;
    logic [DATA_W-1:0] read_value_q;
    logic [DATA_W-1:0] shadow_rdata;
    logic core_wr;
    logic mode_status_wr;
    logic page_ext_wr;
    logic shadow_wr;
    logic far_transfer;
    logic acc_access;
    logic overlay_select;
    logic [VECTOR_POINTER_W-1:0] vector_pointer;
    program_address_type next_fetch;

    function automatic logic in_core_window(input logic [MMR_ADDR_W-1:0] a);
        in_core_window = (a <= MMR_LAST);
    endfunction

    // low block of every page is on-chip only when the overlay is set
    function automatic logic routes_on_chip(input logic overlay, input logic [ADDR_W-1:0] a);
        routes_on_chip = overlay && (a <= COMMON_LAST);
    endfunction

    // far ops that move both page and pc
    function automatic logic is_far_transfer(input far_op_type op);
        is_far_transfer = op inside {OP_FAR_BRANCH, OP_FAR_BRANCH_ACC, OP_FAR_CALL,
            OP_FAR_CALL_ACC, OP_FAR_RETURN, OP_FAR_RETURN_IE};
    endfunction

    // program reads and writes by accumulator borrow the lines for one fetch
    function automatic logic is_acc_access(input far_op_type op);
        is_acc_access = (op == OP_PROG_READ_ACC) || (op == OP_PROG_WRITE_ACC);
    endfunction

    assign overlay_select = mode_status_q[OVERLAY_BIT];
    assign vector_pointer = mode_status_q[VECTOR_POINTER_LSB +: VECTOR_POINTER_W];
    assign core_wr = REG_WR && in_core_window(REG_ADDR);
    assign mode_status_wr = REG_WR && (REG_ADDR == MODE_STATUS_OFFSET);
    assign page_ext_wr = REG_WR && (REG_ADDR == PAGE_EXT_OFFSET);
    assign shadow_wr = core_wr && !mode_status_wr && !page_ext_wr;
    assign far_transfer = FAR_VALID && is_far_transfer(FAR_REQ.op);
    assign acc_access = FAR_VALID && is_acc_access(FAR_REQ.op);

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            mode_status_q <= MODE_STATUS_RESET;
        end
        else if (mode_status_wr)
        begin
            mode_status_q <= REG_WDATA;
        end
    end

    // trap on the same cycle as a far op: trap wins, page held
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            page_ext_q <= PAGE_EXT_RESET;
        end
        else if (TRAP_TAKE)
        begin
            page_ext_q <= page_ext_q;
        end
        else if (far_transfer)
        begin
            page_ext_q <= FAR_REQ.page;
        end
        else if (page_ext_wr)
        begin
            page_ext_q <= REG_WDATA[PAGE_W-1:0];
        end
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            pc_q <= RESET_VECTOR;
        end
        else if (TRAP_TAKE)
        begin
            // vector slot = pointer page plus four words per source
            pc_q <= {vector_pointer, TRAP_NUMBER, VECTOR_STRIDE_SHIFT'(0)};
        end
        else if (far_transfer)
        begin
            pc_q <= FAR_REQ.addr;
        end
        else
        begin
            pc_q <= PC_NEXT;
        end
    end

    // one stage here keeps accumulator accesses on the same pin timing as far ops
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            acc_valid_q <= 1'b0;
            acc_write_q <= 1'b0;
            acc_page_q <= PAGE_EXT_RESET;
            acc_addr_q <= RESET_VECTOR;
        end
        else
        begin
            acc_valid_q <= acc_access;
            acc_write_q <= FAR_VALID && (FAR_REQ.op == OP_PROG_WRITE_ACC);
            acc_page_q <= FAR_REQ.page;
            acc_addr_q <= FAR_REQ.addr;
        end
    end

    always_comb
    begin
        next_fetch.page = page_ext_q;
        next_fetch.addr = pc_q;
        if (acc_valid_q)
        begin
            next_fetch.page = acc_page_q;
            next_fetch.addr = acc_addr_q;
        end
        next_fetch.on_chip = routes_on_chip(overlay_select, next_fetch.addr);
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            page_out_q <= PAGE_EXT_RESET;
            addr_out_q <= RESET_VECTOR;
            on_chip_q <= 1'b0;
            write_q <= 1'b0;
        end
        else
        begin
            page_out_q <= next_fetch.page;
            addr_out_q <= next_fetch.addr;
            on_chip_q <= next_fetch.on_chip;
            write_q <= acc_valid_q && acc_write_q;
        end
    end

    mmr_shadow u_shadow (
        .clk(CLOCK),
        .rst(RST),
        .wr_en(shadow_wr),
        .wr_addr(REG_ADDR[4:0]),
        .wr_data(REG_WDATA),
        .rd_addr(REG_ADDR[4:0]),
        .rd_data(shadow_rdata)
    );

    // source and value are taken on the strobe edge itself
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            read_source_q <= READ_NONE;
            read_value_q <= '0;
        end
        else if (REG_RD && in_core_window(REG_ADDR))
        begin
            if (REG_ADDR == MODE_STATUS_OFFSET)
            begin
                read_source_q <= READ_MODE_STATUS;
                read_value_q <= mode_status_q;
            end
            else if (REG_ADDR == PAGE_EXT_OFFSET)
            begin
                read_source_q <= READ_PAGE_EXT;
                read_value_q <= {{(DATA_W-PAGE_W){1'b0}}, page_ext_q};
            end
            else
            begin
                read_source_q <= READ_SHADOW;
                read_value_q <= '0;
            end
        end
        else
        begin
            read_source_q <= READ_NONE;
            read_value_q <= '0;
        end
    end

    // a plain select between two flops: a further register would cost the
    // one-cycle answer, since the store already registers its read word
    assign REG_RDATA = (read_source_q == READ_SHADOW) ? shadow_rdata : read_value_q;

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            PROGRAM_COUNTER <= RESET_VECTOR;
            UPPER_PROGRAM_ADDRESS_LINES <= PAGE_EXT_RESET;
            PROGRAM_ADDRESS <= RESET_VECTOR;
            PROGRAM_ON_CHIP <= 1'b0;
            PROGRAM_WRITE <= 1'b0;
            OVERLAY_SELECT <= 1'b0;
        end
        else
        begin
            PROGRAM_COUNTER <= pc_q;
            UPPER_PROGRAM_ADDRESS_LINES <= page_out_q;
            PROGRAM_ADDRESS <= addr_out_q;
            PROGRAM_ON_CHIP <= on_chip_q;
            PROGRAM_WRITE <= write_q;
            OVERLAY_SELECT <= overlay_select;
        end
    end
endmodule
`default_nettype wire

// File: program_page_vector_relocation_assertions.sv
// port checker for paging, routing and vector relocation
`timescale 1ns/100ps
`default_nettype none
module page_vector_checker
    import page_vector_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic [MMR_ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire page_vector_pkg::far_request_type FAR_REQ,
    input wire logic FAR_VALID,
    input wire logic TRAP_TAKE,
    input wire logic [4:0] TRAP_NUMBER,
    input wire logic [ADDR_W-1:0] PROGRAM_COUNTER,
    input wire logic [PAGE_W-1:0] UPPER_PROGRAM_ADDRESS_LINES,
    input wire logic [ADDR_W-1:0] PROGRAM_ADDRESS,
    input wire logic PROGRAM_ON_CHIP,
    input wire logic PROGRAM_WRITE,
    input wire logic OVERLAY_SELECT
);
    logic [VECTOR_POINTER_W-1:0] ptr_q;
    logic go;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // trap wins over a far transfer on the same edge; accumulator accesses still go out
    assign go = FAR_VALID && !TRAP_TAKE;
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            ptr_q <= '1;
        else if (REG_WR && REG_ADDR == MODE_STATUS_OFFSET)
            ptr_q <= REG_WDATA[VECTOR_POINTER_LSB +: VECTOR_POINTER_W];
    end
    property p_rst; $fell(RST) |-> PROGRAM_COUNTER == 16'hFF80 && !UPPER_PROGRAM_ADDRESS_LINES;
    endproperty
    a_rst: assert property (p_rst) else $error("reset vector or page");
    property p_pc; go && FAR_REQ.op inside {[1:6]} |-> ##2
        PROGRAM_COUNTER == $past(FAR_REQ.addr, 2);
    endproperty
    a_pc: assert property (p_pc) else $error("pc after far op");
    property p_pg; go && FAR_REQ.op != OP_NONE |-> ##3 {UPPER_PROGRAM_ADDRESS_LINES,
        PROGRAM_ADDRESS} == {$past(FAR_REQ.page, 3), $past(FAR_REQ.addr, 3)}; endproperty
    a_pg: assert property (p_pg) else $error("extended address");
    property p_wr; go && FAR_REQ.op == OP_PROG_WRITE_ACC |-> ##3 PROGRAM_WRITE; endproperty
    a_wr: assert property (p_wr) else $error("program write missing");
    property p_trap; TRAP_TAKE |-> ##2
        PROGRAM_COUNTER == {$past(ptr_q, 2), $past(TRAP_NUMBER, 2), 2'b00};
    endproperty
    a_trap: assert property (p_trap) else $error("vector address");
    property p_out; REG_RD && REG_ADDR > MMR_LAST |=> REG_RDATA == '0; endproperty
    a_out: assert property (p_out) else $error("read outside core window");
    property p_idle; !REG_RD |=> REG_RDATA == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_route; $stable(OVERLAY_SELECT) && OVERLAY_SELECT == $past(OVERLAY_SELECT, 2)
        |-> PROGRAM_ON_CHIP == (OVERLAY_SELECT && PROGRAM_ADDRESS <= COMMON_LAST); endproperty
    a_route: assert property (p_route) else $error("common block routing");
    c_trap: cover property (TRAP_TAKE);
    c_far: cover property (go && FAR_REQ.op == OP_PROG_WRITE_ACC);
    c_chip: cover property (PROGRAM_ON_CHIP);
endmodule
bind program_page_vector_relocation page_vector_checker u_chk (.CLOCK, .RST, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .FAR_REQ, .FAR_VALID, .TRAP_TAKE, .TRAP_NUMBER,
    .PROGRAM_COUNTER, .UPPER_PROGRAM_ADDRESS_LINES, .PROGRAM_ADDRESS, .PROGRAM_ON_CHIP,
    .PROGRAM_WRITE, .OVERLAY_SELECT);
`default_nettype wire

// File: ext_program_memory.sv
// external program memory model on the extended address bus
`timescale 1ns/100ps
`default_nettype none
module ext_program_memory
    import page_vector_pkg::*;
(
    input wire logic clk,
    input wire logic [PAGE_W-1:0] page,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic on_chip,
    output logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] last_q = '0;
    // deselected bus flips each cycle so a stale word never looks valid
    always_ff @(posedge clk)
        last_q <= rdata;
    assign rdata = on_chip ? ~last_q : addr ^ {4{page}};
endmodule
`default_nettype wire

// File: program_page_vector_relocation_tb_top.sv
// self-checking bench for paging, routing and vector relocation
`timescale 1ns/100ps
`default_nettype none
module program_page_vector_relocation_tb_top;
    import page_vector_pkg::*;
    logic CLOCK = 0, RST = 1, REG_WR = 0, REG_RD = 0, FAR_VALID = 0, TRAP_TAKE = 0;
    logic [7:0] REG_ADDR = '0;
    logic [4:0] TRAP_NUMBER = '0;
    logic [15:0] REG_WDATA = '0, PC_NEXT = 16'h8000;
    logic [15:0] REG_RDATA, PROGRAM_COUNTER, PROGRAM_ADDRESS, mem_data;
    logic [3:0] UPPER_PROGRAM_ADDRESS_LINES;
    logic PROGRAM_ON_CHIP, PROGRAM_WRITE, OVERLAY_SELECT;
    far_request_type FAR_REQ = '0;
    int errors = 0, compares = 0;
    always #20 CLOCK = ~CLOCK;
    program_page_vector_relocation u_dut (.CLOCK, .RST, .REG_ADDR, .REG_WDATA, .REG_WR,
        .REG_RD, .REG_RDATA, .FAR_REQ, .FAR_VALID, .TRAP_TAKE, .TRAP_NUMBER, .PC_NEXT,
        .PROGRAM_COUNTER, .UPPER_PROGRAM_ADDRESS_LINES, .PROGRAM_ADDRESS, .PROGRAM_ON_CHIP,
        .PROGRAM_WRITE, .OVERLAY_SELECT);
    ext_program_memory u_mem (.clk(CLOCK), .page(UPPER_PROGRAM_ADDRESS_LINES),
        .addr(PROGRAM_ADDRESS), .on_chip(PROGRAM_ON_CHIP), .rdata(mem_data));
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic reset8;
        RST <= 1;
        repeat (8) @(posedge CLOCK);
        RST <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1;
        @(posedge CLOCK);
        REG_WR <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        REG_ADDR <= a;
        REG_RD <= 1;
        @(posedge CLOCK);
        REG_RD <= 0;
        #1 chk(REG_RDATA, e);
        @(posedge CLOCK);
    endtask
    // page lines trail the taking edge by two cycles, pc by one
    task automatic far(input logic [3:0] op, pg, input logic [15:0] ad, input logic oc);
        FAR_REQ <= {op, pg, ad};
        FAR_VALID <= 1;
        @(posedge CLOCK);
        FAR_VALID <= 0;
        @(posedge CLOCK);
        #1 if (op < 4'h7) chk(PROGRAM_COUNTER, ad);
        @(posedge CLOCK);
        #1 chk({UPPER_PROGRAM_ADDRESS_LINES, PROGRAM_ADDRESS}, {pg, ad});
        chk({PROGRAM_WRITE, PROGRAM_ON_CHIP}, {op == 4'h8, oc});
        if (!oc) chk(mem_data, ad ^ {4{pg}});
        @(posedge CLOCK);
    endtask
    task automatic trap(input logic [4:0] n, input logic [15:0] e);
        TRAP_NUMBER <= n;
        TRAP_TAKE <= 1;
        @(posedge CLOCK);
        TRAP_TAKE <= 0;
        @(posedge CLOCK);
        #1 chk(PROGRAM_COUNTER, e);
        @(posedge CLOCK);
    endtask
    initial
    begin
        reset8;
        rd(MODE_STATUS_OFFSET, 16'hFF80);
        rd(PAGE_EXT_OFFSET, 16'h0000);
        wr(PAGE_EXT_OFFSET, 16'hFFF5);
        rd(PAGE_EXT_OFFSET, 16'h0005);
        wr(8'h05, 16'hA5C3);
        rd(8'h05, 16'hA5C3);
        wr(8'h20, 16'h1234);
        rd(8'h20, 16'h0000);
        for (int i = 1; i < 9; i++)
            far(4'(i), 4'(i), 16'h1230 + 16'(i), 1'b0);
        far(4'h1, 4'hF, 16'hFFFF, 1'b0);
        far(4'h1, 4'h2, 16'h5FFF, 1'b0);
        wr(MODE_STATUS_OFFSET, 16'hFFA0);
        far(4'h1, 4'h2, 16'h5FFF, 1'b1);
        far(4'h1, 4'hF, 16'h6000, 1'b0);
        chk(OVERLAY_SELECT, 1'b1);
        wr(MODE_STATUS_OFFSET, 16'h0100);
        trap(5'd1, 16'h0104);
        trap(5'd31, 16'h017C);
        reset8;
        trap(5'd2, 16'hFF88);
        close_out;
    end
    initial
    begin
        #20000;
        errors++;
        close_out;
    end
endmodule
`default_nettype wire
